// ---- design/hs_switch_ctrl.sv ----
`timescale 1ns/10ps
module hs_switch_ctrl #(
  parameter int WD_CYC_0 = hs_switch_pkg::WD_CYC_0,
  parameter int WD_CYC_1 = hs_switch_pkg::WD_CYC_1,
  parameter int WD_CYC_2 = hs_switch_pkg::WD_CYC_2,
  parameter int WD_CYC_3 = hs_switch_pkg::WD_CYC_3,
  parameter int OCL_CYC_0 = hs_switch_pkg::OCL_CYC_0,
  parameter int OCL_CYC_1 = hs_switch_pkg::OCL_CYC_1,
  parameter int OCL_CYC_2 = hs_switch_pkg::OCL_CYC_2,
  parameter int OCL_CYC_3 = hs_switch_pkg::OCL_CYC_3
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reset_in_n,
  input wire logic wake_in,
  input wire logic failsafe_select_input,
  input wire logic [1:0] direct_input,
  input wire logic [hs_switch_pkg::CUR_W-1:0] load_current_0,
  input wire logic [hs_switch_pkg::CUR_W-1:0] load_current_1,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [1:0] high_side_output,
  output logic [hs_switch_pkg::CUR_W-1:0] current_sense_output,
  output logic current_sense_oe,
  output logic irq
);
  localparam int CW = hs_switch_pkg::CUR_W;
  localparam int WCW = hs_switch_pkg::WD_CW;
  localparam int LCW = hs_switch_pkg::OCL_CW;
  localparam int HCW = hs_switch_pkg::OCH_CW;
  localparam int IRQ_WL = hs_switch_pkg::IRQ_W;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  spi_cmd_if link ();

  spi_frame_rx u_rx (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_si(spi_si),
    .spi_so(spi_so),
    .spi_so_oe(spi_so_oe),
    .link(link.rx)
  );

  // pin synchronisers: reset, wake, fail-safe select, direct inputs
  logic [4:0] pin_meta, pin_sync;
  logic rst_pin, rst_pin_d, wake_s, fsi_s, rst_rise;
  logic [1:0] dir_s;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
      rst_pin_d <= 1'b0;
    end else begin
      pin_meta <= {reset_in_n, wake_in, failsafe_select_input, direct_input};
      pin_sync <= pin_meta;
      rst_pin_d <= pin_sync[4];
    end
  end

  assign rst_pin = pin_sync[4];
  assign wake_s = pin_sync[3];
  assign fsi_s = pin_sync[2];
  assign dir_s = pin_sync[1:0];
  assign rst_rise = rst_pin && !rst_pin_d;

  // operating mode
  hs_switch_pkg::mode_t mode, next_mode;
  logic wd_expire;

  always_comb begin
    next_mode = mode;
    case (mode)
      hs_switch_pkg::MODE_SLEEP: begin
        if (rst_pin) next_mode = hs_switch_pkg::MODE_NORMAL;
      end
      hs_switch_pkg::MODE_NORMAL: begin
        if (!rst_pin) next_mode = hs_switch_pkg::MODE_SLEEP;
        else if (wd_expire) next_mode = hs_switch_pkg::MODE_FAILSAFE;
      end
      hs_switch_pkg::MODE_FAILSAFE: begin
        if (!rst_pin) next_mode = hs_switch_pkg::MODE_SLEEP;
      end
      default: next_mode = hs_switch_pkg::MODE_SLEEP;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) mode <= hs_switch_pkg::MODE_SLEEP;
    else mode <= next_mode;
  end

  // configuration
  logic [7:0] ctrl, timing, ocl_lvl, och_lvl;
  logic [7:0] next_ctrl, next_timing, next_ocl_lvl, next_och_lvl;
  logic [7:0] spi_val;

  always_comb begin
    next_ctrl = ctrl;
    next_timing = timing;
    next_ocl_lvl = ocl_lvl;
    next_och_lvl = och_lvl;
    spi_val = {2'h0, link.frame_data[hs_switch_pkg::SPI_DATA_W-1:0]};
    if (mode != hs_switch_pkg::MODE_NORMAL) begin
      // sleep and fail-safe both force defaults
      next_ctrl = hs_switch_pkg::CTRL_RST;
      next_timing = hs_switch_pkg::TIMING_RST;
      next_ocl_lvl = hs_switch_pkg::OCL_LVL_RST;
      next_och_lvl = hs_switch_pkg::OCH_LVL_RST;
    end else if (link.frame_valid) begin
      // serial write beats a same-cycle port write
      case (link.frame_data[hs_switch_pkg::SPI_ADDR_LSB +: 2])
        2'h0: next_ctrl = spi_val;
        2'h1: next_timing = spi_val;
        2'h2: next_ocl_lvl = spi_val;
        2'h3: next_och_lvl = spi_val;
        default: next_ctrl = ctrl;
      endcase
    end else if (reg_wr) begin
      case (reg_addr)
        hs_switch_pkg::REG_CTRL: next_ctrl = reg_wdata;
        hs_switch_pkg::REG_TIMING: next_timing = reg_wdata;
        hs_switch_pkg::REG_OCL_LVL: next_ocl_lvl = reg_wdata;
        hs_switch_pkg::REG_OCH_LVL: next_och_lvl = reg_wdata;
        default: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl <= hs_switch_pkg::CTRL_RST;
      timing <= hs_switch_pkg::TIMING_RST;
      ocl_lvl <= hs_switch_pkg::OCL_LVL_RST;
      och_lvl <= hs_switch_pkg::OCH_LVL_RST;
    end else begin
      ctrl <= next_ctrl;
      timing <= next_timing;
      ocl_lvl <= next_ocl_lvl;
      och_lvl <= next_och_lvl;
    end
  end

  // watchdog
  logic [WCW-1:0] wd_cnt, next_wd_cnt, wd_limit;
  logic wd_enable;

  always_comb begin
    case (timing[hs_switch_pkg::TIM_WD_LSB +: 2])
      2'h1: wd_limit = WCW'(WD_CYC_1 - 1);
      2'h2: wd_limit = WCW'(WD_CYC_2 - 1);
      2'h3: wd_limit = WCW'(WD_CYC_3 - 1);
      default: wd_limit = WCW'(WD_CYC_0 - 1);
    endcase
    // grounded select input stops the watchdog and so fail-safe entry
    wd_enable = wake_s && fsi_s && (mode == hs_switch_pkg::MODE_NORMAL);
    wd_expire = wd_enable && (wd_cnt >= wd_limit);
    if (!wd_enable || rst_rise || link.frame_valid || wd_expire)
      next_wd_cnt = '0;
    else
      next_wd_cnt = wd_cnt + 1'b1;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) wd_cnt <= '0;
    else wd_cnt <= next_wd_cnt;
  end

  // output request and overcurrent per channel
  logic [1:0] drive_req, oc_fault, oc_trip, next_hso;
  logic [LCW-1:0] ocl_limit;
  logic [CW-1:0] cur [2];

  assign cur[0] = load_current_0;
  assign cur[1] = load_current_1;

  always_comb begin
    case (timing[hs_switch_pkg::TIM_OCL_LSB +: 2])
      2'h1: ocl_limit = LCW'(OCL_CYC_1 - 1);
      2'h2: ocl_limit = LCW'(OCL_CYC_2 - 1);
      2'h3: ocl_limit = LCW'(OCL_CYC_3 - 1);
      default: ocl_limit = LCW'(OCL_CYC_0 - 1);
    endcase
  end

  genvar g;
  for (g = 0; g < 2; g++) begin : g_ch
    logic [HCW-1:0] on_cnt, next_on_cnt;
    logic [LCW-1:0] low_cnt, next_low_cnt;
    logic fault_q, next_fault, och_phase, over_lo, over_hi, trip;

    always_comb begin
      if (mode == hs_switch_pkg::MODE_SLEEP)
        drive_req[g] = 1'b0;
      else if (mode == hs_switch_pkg::MODE_NORMAL &&
               !ctrl[hs_switch_pkg::CTRL_DIRECT_LSB + g])
        drive_req[g] = ctrl[hs_switch_pkg::CTRL_SER_ON_LSB + g];
      else
        drive_req[g] = dir_s[g];
      och_phase = on_cnt < HCW'(hs_switch_pkg::OCH_CYC);
      over_lo = cur[g] > ocl_lvl[CW-1:0];
      over_hi = cur[g] > och_lvl[CW-1:0];
      // short window sees only the high level, then the low level with blanking
      trip = drive_req[g] && !fault_q &&
             (och_phase ? over_hi : (over_lo && low_cnt >= ocl_limit));
      next_on_cnt = !drive_req[g] ? '0 :
                    (och_phase ? on_cnt + 1'b1 : on_cnt);
      if (!drive_req[g] || och_phase || !over_lo || fault_q)
        next_low_cnt = '0;
      else
        next_low_cnt = low_cnt + 1'b1;
      // fault latches until the request drops; pwm off-phases rearm it
      next_fault = drive_req[g] && (fault_q || trip);
    end

    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        on_cnt <= '0;
        low_cnt <= '0;
        fault_q <= 1'b0;
      end else begin
        on_cnt <= next_on_cnt;
        low_cnt <= next_low_cnt;
        fault_q <= next_fault;
      end
    end

    assign oc_fault[g] = fault_q;
    assign oc_trip[g] = trip;
    assign next_hso[g] = drive_req[g] && !next_fault;

    a_och_trip: assert property (drive_req[g] && !fault_q && och_phase &&
      over_hi |=> !high_side_output[g])
      else $error("high overcurrent in blank window did not trip");
    a_ocl_level_hold: assert property (drive_req[g] && !fault_q &&
      !och_phase && !over_lo ##1 drive_req[g] |-> high_side_output[g])
      else $error("output dropped below programmed low level");
  end

  // sense, interrupts, register read
  logic [CW-1:0] next_sense;
  logic next_sense_oe, next_irq;
  logic [IRQ_WL-1:0] irq_stat, irq_mask, next_irq_stat, next_irq_mask;
  logic [IRQ_WL-1:0] ev, w1c;
  logic [7:0] status_word, next_rdata;

  always_comb begin
    next_sense = ctrl[hs_switch_pkg::CTRL_SENSE_SEL] ? cur[1] : cur[0];
    next_sense_oe = !ctrl[hs_switch_pkg::CTRL_SENSE_HIZ] &&
                    (mode != hs_switch_pkg::MODE_SLEEP);
    ev = {link.frame_valid, oc_trip, wd_expire};
    w1c = (reg_wr && reg_addr == hs_switch_pkg::REG_IRQ_STAT) ?
          reg_wdata[IRQ_WL-1:0] : '0;
    // a new event wins over a same-cycle clear
    next_irq_stat = (irq_stat & ~w1c) | ev;
    next_irq_mask = (reg_wr && reg_addr == hs_switch_pkg::REG_IRQ_MASK) ?
                    reg_wdata[IRQ_WL-1:0] : irq_mask;
    next_irq = |(next_irq_stat & next_irq_mask);
    status_word = {1'b0, mode, oc_fault, wake_s, fsi_s};
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        hs_switch_pkg::REG_CTRL: next_rdata = ctrl;
        hs_switch_pkg::REG_TIMING: next_rdata = timing;
        hs_switch_pkg::REG_OCL_LVL: next_rdata = ocl_lvl;
        hs_switch_pkg::REG_OCH_LVL: next_rdata = och_lvl;
        hs_switch_pkg::REG_STATUS: next_rdata = status_word;
        hs_switch_pkg::REG_IRQ_STAT: next_rdata = {4'h0, irq_stat};
        hs_switch_pkg::REG_IRQ_MASK: next_rdata = {4'h0, irq_mask};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  assign link.status_byte = status_word;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      high_side_output <= 2'h0;
      current_sense_output <= '0;
      current_sense_oe <= 1'b0;
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      high_side_output <= next_hso;
      current_sense_output <= next_sense;
      current_sense_oe <= next_sense_oe;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      irq <= next_irq;
      reg_rdata <= next_rdata;
    end
  end

  a_sleep_outputs_off: assert property (mode == hs_switch_pkg::MODE_SLEEP
    |=> high_side_output == 2'h0)
    else $error("output on during sleep");
  a_reset_pin_sleep: assert property (!rst_pin
    |=> mode == hs_switch_pkg::MODE_SLEEP)
    else $error("low reset pin did not give sleep");
  a_cfg_reset_low: assert property (!rst_pin [*2] |=>
    ctrl == hs_switch_pkg::CTRL_RST && ocl_lvl == hs_switch_pkg::OCL_LVL_RST
    && !oc_fault[0] && !oc_fault[1])
    else $error("state not initial while reset pin low");
  a_wdog_start: assert property (rst_rise ##1 (wake_s && fsi_s && rst_pin
    && !link.frame_valid) |=> wd_cnt == 1)
    else $error("watchdog did not start at reset release");
  a_wdog_needs_wake: assert property (!wake_s |=> wd_cnt == 0)
    else $error("watchdog counts without wake");
  a_fsi_ground: assert property (!fsi_s && mode == hs_switch_pkg::MODE_NORMAL
    |=> mode != hs_switch_pkg::MODE_FAILSAFE && wd_cnt == 0)
    else $error("watchdog active with select input grounded");
  a_wdog_failsafe: assert property (wd_expire && rst_pin |=>
    mode == hs_switch_pkg::MODE_FAILSAFE ##1
    ctrl == hs_switch_pkg::CTRL_RST)
    else $error("expiry did not give fail-safe defaults");
  a_frame_restart: assert property (link.frame_valid |=> wd_cnt == 0)
    else $error("serial transfer did not restart watchdog");
  a_direct_low_off: assert property (mode != hs_switch_pkg::MODE_SLEEP &&
    (mode == hs_switch_pkg::MODE_FAILSAFE ||
    ctrl[hs_switch_pkg::CTRL_DIRECT_LSB]) && !dir_s[0]
    |=> !high_side_output[0])
    else $error("output 0 on with direct input low");
  a_serial_off: assert property (mode == hs_switch_pkg::MODE_NORMAL &&
    !ctrl[hs_switch_pkg::CTRL_DIRECT_LSB + 1] &&
    !ctrl[hs_switch_pkg::CTRL_SER_ON_LSB + 1] |=> !high_side_output[1])
    else $error("output 1 on while serially off");
  a_sense_select: assert property (!ctrl[hs_switch_pkg::CTRL_SENSE_HIZ] &&
    ctrl[hs_switch_pkg::CTRL_SENSE_SEL] && mode != hs_switch_pkg::MODE_SLEEP
    |=> current_sense_oe && current_sense_output == $past(load_current_1))
    else $error("sense not routed to output 1");
  a_sense_hiz: assert property (ctrl[hs_switch_pkg::CTRL_SENSE_HIZ]
    |=> !current_sense_oe)
    else $error("sense driven while tri-state requested");
  a_irq_wdog: assert property (wd_expire && irq_mask[hs_switch_pkg::IRQ_WDOG]
    && !(reg_wr && reg_addr == hs_switch_pkg::REG_IRQ_MASK) |=> irq [*2])
    else $error("watchdog event lost from interrupt");

  c_failsafe: cover property (mode == hs_switch_pkg::MODE_FAILSAFE);
  c_reset_release: cover property (rst_rise ##[500:1000] link.frame_valid);
  c_overcurrent: cover property (|oc_trip);
  c_irq_clear: cover property (irq ##1 !irq);
endmodule

// ---- design/hs_switch_pkg.sv ----
package hs_switch_pkg;

  // core clock
  localparam int CLK_MHZ = 100;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TIMING = 4'h1;
  localparam logic [3:0] REG_OCL_LVL = 4'h2;
  localparam logic [3:0] REG_OCH_LVL = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_IRQ_STAT = 4'h5;
  localparam logic [3:0] REG_IRQ_MASK = 4'h6;

  // control fields
  localparam int CTRL_SER_ON_LSB = 0;
  localparam int CTRL_DIRECT_LSB = 2;
  localparam int CTRL_SENSE_SEL = 4;
  localparam int CTRL_SENSE_HIZ = 5;
  localparam int TIM_WD_LSB = 0;
  localparam int TIM_OCL_LSB = 2;

  // reset values: both direct inputs in control, sense on output 0
  localparam logic [7:0] CTRL_RST = 8'h0C;
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [7:0] OCL_LVL_RST = 8'h20;
  localparam logic [7:0] OCH_LVL_RST = 8'h30;

  // serial command: register select on top, value below
  localparam int SPI_FRAME_W = 8;
  localparam int SPI_ADDR_LSB = 6;
  localparam int SPI_DATA_W = 6;

  // load current sample width
  localparam int CUR_W = 6;

  // interrupt bits
  localparam int IRQ_WDOG = 0;
  localparam int IRQ_OC0 = 1;
  localparam int IRQ_FRAME = 3;
  localparam int IRQ_W = 4;

  // watchdog periods in ms, typical
  localparam int WD_MS_0 = 620;
  localparam int WD_MS_1 = 310;
  localparam int WD_MS_2 = 2500;
  localparam int WD_MS_3 = 1250;
  localparam int WD_CYC_0 = WD_MS_0 * 1000 * CLK_MHZ;
  localparam int WD_CYC_1 = WD_MS_1 * 1000 * CLK_MHZ;
  localparam int WD_CYC_2 = WD_MS_2 * 1000 * CLK_MHZ;
  localparam int WD_CYC_3 = WD_MS_3 * 1000 * CLK_MHZ;
  localparam int WD_CW = 28;

  // low overcurrent blanking in us, typical
  localparam int OCL_US_0 = 155000;
  localparam int OCL_US_1 = 10000;
  localparam int OCL_US_2 = 1200;
  localparam int OCL_US_3 = 150;
  localparam int OCL_CYC_0 = OCL_US_0 * CLK_MHZ;
  localparam int OCL_CYC_1 = OCL_US_1 * CLK_MHZ;
  localparam int OCL_CYC_2 = OCL_US_2 * CLK_MHZ;
  localparam int OCL_CYC_3 = OCL_US_3 * CLK_MHZ;
  localparam int OCL_CW = 24;

  // high overcurrent blanking in us, typical
  localparam int OCH_US = 10;
  localparam int OCH_CYC = OCH_US * CLK_MHZ;
  localparam int OCH_CW = 11;

  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h1,
    MODE_NORMAL = 3'h2,
    MODE_FAILSAFE = 3'h4
  } mode_t;

endpackage

// ---- design/spi_cmd_if.sv ----
`timescale 1ns/10ps
interface spi_cmd_if;
  logic frame_valid;
  logic [7:0] frame_data;
  logic [7:0] status_byte;
  modport rx (output frame_valid, output frame_data, input status_byte);
  modport core (input frame_valid, input frame_data, output status_byte);
endinterface

// ---- design/spi_frame_rx.sv ----
`timescale 1ns/10ps
module spi_frame_rx (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  spi_cmd_if.rx link
);
  logic [2:0] meta;
  logic [2:0] sync;
  logic sclk_d;
  logic [7:0] shift_in, next_shift_in;
  logic [7:0] shift_out, next_shift_out;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic next_so, next_so_oe, next_valid;
  logic [7:0] next_data;
  logic cs_act, sclk_rise, sclk_fall, cs_d;
  localparam int SPI_FRAME_W_L = hs_switch_pkg::SPI_FRAME_W;

  // link pins are sampled by mclk; sclk edges found after the 2nd stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // idle pin levels, so no false sclk edge follows reset
      meta <= 3'h4;
      sync <= 3'h4;
      sclk_d <= 1'b0;
      cs_d <= 1'b0;
    end else begin
      meta <= {spi_cs_n, spi_sclk, spi_si};
      sync <= meta;
      sclk_d <= sync[1];
      cs_d <= !sync[2];
    end
  end

  always_comb begin
    cs_act = !sync[2];
    sclk_rise = sync[1] && !sclk_d;
    sclk_fall = !sync[1] && sclk_d;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_bit_cnt = bit_cnt;
    next_so = spi_so;
    next_valid = 1'b0;
    next_data = link.frame_data;
    next_so_oe = cs_act;
    if (!cs_act) begin
      next_bit_cnt = 4'h0;
    end else if (!cs_d) begin
      // new frame: present status msb first
      next_shift_out = {link.status_byte[6:0], 1'b0};
      next_so = link.status_byte[7];
      next_bit_cnt = 4'h0;
    end else if (sclk_rise && bit_cnt < 4'(SPI_FRAME_W_L)) begin
      next_shift_in = {shift_in[6:0], sync[0]};
      next_bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == 4'(SPI_FRAME_W_L - 1)) begin
        next_valid = 1'b1;
        next_data = {shift_in[6:0], sync[0]};
      end
    end else if (sclk_fall) begin
      next_so = shift_out[7];
      next_shift_out = {shift_out[6:0], 1'b0};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      bit_cnt <= 4'h0;
      spi_so <= 1'b0;
      spi_so_oe <= 1'b0;
      link.frame_valid <= 1'b0;
      link.frame_data <= 8'h00;
    end else begin
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      bit_cnt <= next_bit_cnt;
      spi_so <= next_so;
      spi_so_oe <= next_so_oe;
      link.frame_valid <= next_valid;
      link.frame_data <= next_data;
    end
  end
endmodule

// ---- tb/host_model.sv ----
`timescale 1ns/10ps
module host_model (
  input wire logic mclk,
  input wire logic reset_in_n,
  input wire logic spi_so,
  input wire logic spi_so_oe,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_si
);
  realtime rst_rise = 0;
  logic [7:0] so_bits;
  initial begin
    spi_cs_n = 1'h1;
    spi_sclk = 1'h0;
    spi_si = 1'h0;
  end
  always @(posedge reset_in_n) rst_rise = $realtime;
  // sclk idles low between frames; si released to its pull-down level
  task automatic send(input logic [7:0] frame);
    wait (reset_in_n === 1'h1);
    // pins move just after a core edge, never on one
    @(posedge mclk);
    #2;
    while ($realtime - rst_rise < 5000.0) #10;
    spi_cs_n = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      spi_si = frame[i];
      #80;
      spi_sclk = 1'h1;
      so_bits[i] = spi_so_oe ? spi_so : 1'hx;
      #80;
      spi_sclk = 1'h0;
    end
    #80;
    spi_cs_n = 1'h1;
    spi_si = 1'h0;
    // cs stays high a while, else back-to-back frames merge
    #300;
  endtask
endmodule

// ---- tb/switch_mode_reset_control_bench.sv ----
`timescale 1ns/10ps
module switch_mode_reset_control_bench;
  logic mclk, sys_rst, rst_n, wake;
  logic fs_sel, wr, rd;
  logic [1:0] din;
  logic [5:0] cur0, cur1;
  logic [3:0] addr;
  logic [7:0] wdata;
  wire cs_n, sclk, si, so, so_oe, sense_oe, irq;
  wire [7:0] rdata;
  wire [1:0] hs;
  wire [5:0] sense;
  int mismatches = 0, comparisons = 0, cyc = 0;

  // short watchdog and blanking counts keep the run brief
  // only the periods the scenarios reach are shortened
  hs_switch_ctrl #(.WD_CYC_0(400), .WD_CYC_1(200), .OCL_CYC_0(2300))
    dut_u (
    .mclk(mclk), .sys_rst(sys_rst), .reset_in_n(rst_n), .wake_in(wake),
    .failsafe_select_input(fs_sel), .direct_input(din),
    .load_current_0(cur0), .load_current_1(cur1), .spi_cs_n(cs_n),
    .spi_sclk(sclk), .spi_si(si), .spi_so(so), .spi_so_oe(so_oe),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .high_side_output(hs),
    .current_sense_output(sense), .current_sense_oe(sense_oe),
    .irq(irq));
  host_model host_u (.mclk(mclk), .reset_in_n(rst_n), .spi_so(so),
    .spi_so_oe(so_oe), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_si(si));

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  task automatic results();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge mclk);
    wr <= 1'h0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'h1;
    @(posedge mclk);
    rd <= 1'h0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic pins(input logic r, w, f, input logic [1:0] d);
    @(posedge mclk);
    rst_n <= r;
    wake <= w;
    fs_sel <= f;
    din <= d;
  endtask

  task automatic t_sleep();
    pins(1'h0, 1'h0, 1'h1, 2'h3);
    tick(6);
    chk({6'h00, hs}, 8'h00);
    rchk(4'h4, 8'h11);
    wreg(4'h0, 8'h03);
    rchk(4'h0, 8'h0C);
    rchk(4'h3, 8'h30);
    rchk(4'h7, 8'h00);
  endtask
  task automatic t_direct();
    pins(1'h1, 1'h0, 1'h1, 2'h0);
    tick(5);
    rchk(4'h4, 8'h21);
    // toggling like a pwm source
    for (int j = 1; j < 5; j++) begin
      @(posedge mclk);
      din <= 2'(j);
      tick(5);
      chk({6'h00, hs}, 8'(j % 4));
    end
  endtask
  task automatic t_serial();
    wreg(4'h0, 8'h03);
    tick(4);
    chk({6'h00, hs}, 8'h03);
    wreg(4'h6, 8'h08);
    host_u.send(8'h0C);
    chk(host_u.so_bits, 8'h21);
    tick(8);
    chk({6'h00, hs}, 8'h00);
    chk({7'h00, irq}, 8'h01);
    wreg(4'h5, 8'h08);
    tick(2);
    chk({7'h00, irq}, 8'h00);
    wreg(4'h6, 8'h00);
    host_u.send(8'h0C);
    tick(8);
    chk({7'h00, irq}, 8'h00);
    rchk(4'h5, 8'h08);
  endtask
  task automatic t_sense();
    @(posedge mclk);
    cur0 <= 6'h0A;
    cur1 <= 6'h15;
    tick(4);
    chk({2'h0, sense}, 8'h0A);
    wreg(4'h0, 8'h1C);
    tick(4);
    chk({2'h0, sense}, 8'h15);
    wreg(4'h0, 8'h2C);
    tick(4);
    chk({7'h00, sense_oe}, 8'h00);
    wreg(4'h0, 8'h0C);
  endtask
  task automatic t_oc();
    host_u.send(8'hD0);
    @(posedge mclk);
    cur0 <= 6'h18;
    din <= 2'h1;
    tick(20);
    chk({6'h00, hs}, 8'h00);
    rchk(4'h4, 8'h25);
    pins(1'h1, 1'h0, 1'h1, 2'h0);
    host_u.send(8'hFF);
    wreg(4'h2, 8'h10);
    pins(1'h1, 1'h0, 1'h1, 2'h1);
    tick(900);
    chk({6'h00, hs}, 8'h01);
    tick(2500);
    chk({6'h00, hs}, 8'h00);
    pins(1'h1, 1'h0, 1'h1, 2'h0);
  endtask
  task automatic t_wdog();
    wreg(4'h6, 8'h01);
    host_u.send(8'h41);
    pins(1'h1, 1'h1, 1'h1, 2'h0);
    repeat (3) host_u.send(8'h41);
    tick(148);
    rchk(4'h4, 8'h23);
    chk({7'h00, irq}, 8'h00);
    tick(80);
    rchk(4'h4, 8'h43);
    chk({7'h00, irq}, 8'h01);
    rchk(4'h1, 8'h00);
    pins(1'h1, 1'h1, 1'h1, 2'h2);
    tick(5);
    chk({6'h00, hs}, 8'h02);
    pins(1'h0, 1'h1, 1'h1, 2'h0);
    tick(5);
    pins(1'h1, 1'h1, 1'h1, 2'h0);
    tick(340);
    rchk(4'h4, 8'h23);
    tick(100);
    rchk(4'h4, 8'h43);
  endtask
  task automatic t_gate(input logic w, f, input logic [7:0] exp);
    pins(1'h0, w, f, 2'h0);
    tick(5);
    pins(1'h1, w, f, 2'h0);
    tick(600);
    rchk(4'h4, exp);
  endtask

  initial begin
    sys_rst <= 1'h1;
    rst_n <= 1'h0;
    wake <= 1'h0;
    fs_sel <= 1'h1;
    wr <= 1'h0;
    rd <= 1'h0;
    din <= 2'h0;
    cur0 <= 6'h00;
    cur1 <= 6'h00;
    addr <= 4'h0;
    wdata <= 8'h00;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'h0;
    t_sleep();
    t_direct();
    t_serial();
    t_sense();
    t_oc();
    t_wdog();
    t_gate(1'h0, 1'h1, 8'h21);
    t_gate(1'h1, 1'h0, 8'h22);
    results();
  end
endmodule
